// ### hdl/mqt_pkg.sv
// Constants, offsets and carrier types of the queue transport register bank.
// Assumes a single clock domain and a 32-bit register data path.
package mqt_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NUM_QUEUES = 4;
	localparam int QIDX_W = 2;
	localparam int FEATURE_WORDS = 2;
	localparam int FSEL_W = 1;
	localparam int CAUSE_W = 2;
	localparam int CAUSE_USED_BIT = 0;
	localparam int CAUSE_CONFIG_BIT = 1;

	localparam logic [ADDR_W-1:0] OFS_SIGNATURE = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_VERSION = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_DEVICE_TYPE = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_VENDOR = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_OFFERED = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_OFFERED_SEL = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_ACCEPTED = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_ACCEPTED_SEL = 12'h024;
	localparam logic [ADDR_W-1:0] OFS_PAGE_SIZE = 12'h028;
	localparam logic [ADDR_W-1:0] OFS_QUEUE_SEL = 12'h030;
	localparam logic [ADDR_W-1:0] OFS_QUEUE_LIMIT = 12'h034;
	localparam logic [ADDR_W-1:0] OFS_QUEUE_SIZE = 12'h038;
	localparam logic [ADDR_W-1:0] OFS_ALIGN = 12'h03C;
	localparam logic [ADDR_W-1:0] OFS_PAGE_NUMBER = 12'h040;
	localparam logic [ADDR_W-1:0] OFS_DOORBELL = 12'h050;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CAUSE = 12'h060;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ACK = 12'h064;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h070;

	localparam logic [DATA_W-1:0] VERSION_LEGACY = 32'h0000_0001;
	localparam logic [DATA_W-1:0] QUEUE_SIZE_MAX = 32'h0000_0100;
	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] PAGE_SIZE_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] SEL_RESET = 32'h0000_0000;
	localparam logic [CAUSE_W-1:0] CAUSE_NONE = 2'h0;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mqt_req_type;

	typedef struct packed {
		logic [DATA_W-1:0] size;
		logic [DATA_W-1:0] align;
		logic active;
	} mqt_qcfg_type;
endpackage

// ### hdl/mqt_page_addr.sv
// Registered product of a queue page number and the guest page size.
// Assumes operands come from logic on the same clock.
`timescale 1ns/1ps
module mqt_page_addr import mqt_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [DATA_W-1:0] i_page_number,
	input wire logic [DATA_W-1:0] i_page_size,
	output logic [2*DATA_W-1:0] o_base_addr
);
	logic [2*DATA_W-1:0] base_addr_r;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			base_addr_r <= '0;
		end else begin
			base_addr_r <= (2*DATA_W)'(i_page_number) * (2*DATA_W)'(i_page_size);
		end
	end

	assign o_base_addr = base_addr_r;
endmodule

// ### hdl/mqt_regs.sv
// Register bank of a page-addressed paravirtual queue transport.
// Assumes a same-clock register port and same-clock event pulses from the queue engine.
`timescale 1ns/1ps
module mqt_regs import mqt_pkg::*; #(
	// Identity values below are arbitrary.
	parameter logic [DATA_W-1:0] SIGNATURE = 32'h5A5A_0001,
	parameter logic [DATA_W-1:0] DEVICE_TYPE = 32'h0000_0001,
	parameter logic [DATA_W-1:0] VENDOR = 32'h0000_ABCD,
	parameter logic [FEATURE_WORDS*DATA_W-1:0] OFFERED_FEATURES = 64'h0000_0000_0000_0003
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire mqt_req_type i_req,
	input wire logic i_used_ring_event,
	input wire logic i_config_event,
	input wire logic [QIDX_W-1:0] i_lookup_idx,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_rvalid,
	output logic o_irq,
	output logic o_doorbell_valid,
	output logic [QIDX_W-1:0] o_doorbell_index,
	output logic o_device_reset,
	output logic [DATA_W-1:0] o_device_status,
	output logic [DATA_W-1:0] o_page_size,
	output logic [FEATURE_WORDS*DATA_W-1:0] o_accepted_features,
	output mqt_qcfg_type o_lookup_cfg,
	output logic [2*DATA_W-1:0] o_lookup_base_addr
);
	function automatic logic hit(input mqt_req_type req, input logic [ADDR_W-1:0] ofs);
		return req.wr_en && (req.addr == ofs);
	endfunction
	function automatic logic queue_exists(input logic [DATA_W-1:0] idx);
		return idx < DATA_W'(NUM_QUEUES);
	endfunction
	function automatic logic is_pow2(input logic [DATA_W-1:0] v);
		return (v != WORD_ZERO) && ((v & (v - 32'h0000_0001)) == WORD_ZERO);
	endfunction
	function automatic logic is_readable(input logic [ADDR_W-1:0] a);
		return a == OFS_SIGNATURE || a == OFS_VERSION || a == OFS_DEVICE_TYPE || a == OFS_VENDOR ||
			a == OFS_OFFERED || a == OFS_QUEUE_LIMIT || a == OFS_PAGE_NUMBER || a == OFS_IRQ_CAUSE ||
			a == OFS_STATUS;
	endfunction
	logic [DATA_W-1:0] queue_sel_r, offered_sel_r, accepted_sel_r, page_size_r, status_r;
	logic [DATA_W-1:0] pfn_r [NUM_QUEUES];
	logic [DATA_W-1:0] size_r [NUM_QUEUES];
	logic [DATA_W-1:0] align_r [NUM_QUEUES];
	logic [CAUSE_W-1:0] cause_r, cause_nxt;
	logic [FEATURE_WORDS*DATA_W-1:0] accepted_r;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic rvalid_r, irq_r, doorbell_valid_r, device_reset_r;
	logic [QIDX_W-1:0] doorbell_index_r;
	mqt_qcfg_type lookup_cfg_r;
	logic sel_ok, dev_reset_wr;
	logic [QIDX_W-1:0] sel_idx;
	logic [DATA_W-1:0] lookup_pfn;
	assign sel_ok = queue_exists(queue_sel_r);
	assign sel_idx = queue_sel_r[QIDX_W-1:0];
	assign dev_reset_wr = hit(i_req, OFS_STATUS) && (i_req.wdata == WORD_ZERO);
	assign lookup_pfn = pfn_r[i_lookup_idx];

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			queue_sel_r <= SEL_RESET;
			offered_sel_r <= SEL_RESET;
			accepted_sel_r <= SEL_RESET;
			page_size_r <= PAGE_SIZE_RESET;
			status_r <= STATUS_RESET;
		end else begin
			if (hit(i_req, OFS_QUEUE_SEL)) begin
				queue_sel_r <= i_req.wdata;
			end
			if (hit(i_req, OFS_OFFERED_SEL)) begin
				offered_sel_r <= i_req.wdata;
			end
			if (hit(i_req, OFS_ACCEPTED_SEL)) begin
				accepted_sel_r <= i_req.wdata;
			end
			if (hit(i_req, OFS_PAGE_SIZE)) begin
				page_size_r <= i_req.wdata;
			end
			if (hit(i_req, OFS_STATUS)) begin
				status_r <= i_req.wdata;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			accepted_r <= '0;
		end else if (hit(i_req, OFS_ACCEPTED) && accepted_sel_r < DATA_W'(FEATURE_WORDS)) begin
			accepted_r[DATA_W*int'(accepted_sel_r[FSEL_W-1:0]) +: DATA_W] <= i_req.wdata;
		end
	end

	// Per-queue state; writes to an absent queue are dropped.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			for (int i = 0; i < NUM_QUEUES; i++) begin
				pfn_r[i] <= WORD_ZERO;
				size_r[i] <= WORD_ZERO;
				align_r[i] <= WORD_ZERO;
			end
		end else begin
			if (hit(i_req, OFS_QUEUE_SIZE) && sel_ok) begin
				size_r[sel_idx] <= i_req.wdata;
			end
			if (hit(i_req, OFS_ALIGN) && sel_ok && is_pow2(i_req.wdata)) begin
				align_r[sel_idx] <= i_req.wdata;
			end
			if (dev_reset_wr) begin
				for (int i = 0; i < NUM_QUEUES; i++) begin
					pfn_r[i] <= WORD_ZERO;
				end
			end else if (hit(i_req, OFS_PAGE_NUMBER) && sel_ok) begin
				pfn_r[sel_idx] <= i_req.wdata;
			end
		end
	end

	always_comb begin
		cause_nxt = cause_r;
		if (hit(i_req, OFS_IRQ_ACK)) begin
			cause_nxt = cause_nxt & ~i_req.wdata[CAUSE_W-1:0];
		end
		if (dev_reset_wr) begin
			cause_nxt = CAUSE_NONE;
		end
		if (i_used_ring_event) begin
			cause_nxt[CAUSE_USED_BIT] = 1'b1;
		end
		if (i_config_event) begin
			cause_nxt[CAUSE_CONFIG_BIT] = 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cause_r <= CAUSE_NONE;
			irq_r <= 1'b0;
		end else begin
			cause_r <= cause_nxt;
			irq_r <= |cause_nxt;
		end
	end

	always_comb begin
		case (i_req.addr)
			OFS_SIGNATURE: rdata_nxt = SIGNATURE;
			OFS_VERSION: rdata_nxt = VERSION_LEGACY;
			OFS_DEVICE_TYPE: rdata_nxt = DEVICE_TYPE;
			OFS_VENDOR: rdata_nxt = VENDOR;
			OFS_OFFERED: rdata_nxt = (offered_sel_r < DATA_W'(FEATURE_WORDS)) ?
				OFFERED_FEATURES[DATA_W*int'(offered_sel_r[FSEL_W-1:0]) +: DATA_W] : WORD_ZERO;
			OFS_QUEUE_LIMIT: rdata_nxt = sel_ok ? QUEUE_SIZE_MAX : WORD_ZERO;
			OFS_PAGE_NUMBER: rdata_nxt = sel_ok ? pfn_r[sel_idx] : WORD_ZERO;
			OFS_IRQ_CAUSE: rdata_nxt = {{(DATA_W-CAUSE_W){1'b0}}, cause_r};
			OFS_STATUS: rdata_nxt = status_r;
			default: rdata_nxt = WORD_ZERO;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			rdata_r <= WORD_ZERO;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= i_req.rd_en;
			rdata_r <= i_req.rd_en ? rdata_nxt : WORD_ZERO;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			doorbell_valid_r <= 1'b0;
			doorbell_index_r <= '0;
			device_reset_r <= 1'b0;
		end else begin
			doorbell_valid_r <= hit(i_req, OFS_DOORBELL) && queue_exists(i_req.wdata);
			if (hit(i_req, OFS_DOORBELL) && queue_exists(i_req.wdata)) begin
				doorbell_index_r <= i_req.wdata[QIDX_W-1:0];
			end
			device_reset_r <= dev_reset_wr;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			lookup_cfg_r <= '0;
		end else begin
			lookup_cfg_r <= '{size: size_r[i_lookup_idx], align: align_r[i_lookup_idx], active: lookup_pfn != WORD_ZERO};
		end
	end

	mqt_page_addr mqt_page_addr_inst (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_page_number(lookup_pfn),
		.i_page_size(page_size_r),
		.o_base_addr(o_lookup_base_addr)
	);

	assign o_rdata = rdata_r;
	assign o_rvalid = rvalid_r;
	assign o_irq = irq_r;
	assign o_doorbell_valid = doorbell_valid_r;
	assign o_doorbell_index = doorbell_index_r;
	assign o_device_reset = device_reset_r;
	assign o_device_status = status_r;
	assign o_page_size = page_size_r;
	assign o_accepted_features = accepted_r;
	assign o_lookup_cfg = lookup_cfg_r;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	property p_irq_level;
		o_irq == (cause_r != CAUSE_NONE);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq differs from cause mask");
	property p_version;
		i_req.rd_en && i_req.addr == OFS_VERSION |=> o_rvalid && o_rdata == VERSION_LEGACY;
	endproperty
	a_version: assert property (p_version) else $error("version read wrong");
	property p_unmapped_zero;
		i_req.rd_en && !is_readable(i_req.addr) |=> o_rvalid && o_rdata == WORD_ZERO;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unreadable offset returned data");
	property p_event_sets;
		i_used_ring_event |=> cause_r[CAUSE_USED_BIT] && o_irq;
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("used ring event not latched");
	property p_ack_clears;
		hit(i_req, OFS_IRQ_ACK) && i_req.wdata[CAUSE_CONFIG_BIT] && !i_config_event |=> !cause_r[CAUSE_CONFIG_BIT];
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear cause");
	property p_cause_holds;
		cause_r[CAUSE_USED_BIT] && !hit(i_req, OFS_IRQ_ACK) && !dev_reset_wr |=> cause_r[CAUSE_USED_BIT];
	endproperty
	a_cause_holds: assert property (p_cause_holds) else $error("cause dropped without ack");
	property p_doorbell_ignore;
		hit(i_req, OFS_DOORBELL) && !queue_exists(i_req.wdata) |=> !o_doorbell_valid;
	endproperty
	a_doorbell_ignore: assert property (p_doorbell_ignore) else $error("absent queue doorbell fired");
	property p_doorbell_fire;
		hit(i_req, OFS_DOORBELL) && queue_exists(i_req.wdata) |=>
			o_doorbell_valid && o_doorbell_index == $past(i_req.wdata[QIDX_W-1:0]);
	endproperty
	a_doorbell_fire: assert property (p_doorbell_fire) else $error("doorbell not forwarded");
	property p_dev_reset;
		dev_reset_wr |=> o_device_reset && pfn_r[0] == WORD_ZERO && pfn_r[NUM_QUEUES-1] == WORD_ZERO;
	endproperty
	a_dev_reset: assert property (p_dev_reset) else $error("device reset left a page number");
	property p_limit_absent;
		i_req.rd_en && i_req.addr == OFS_QUEUE_LIMIT && !sel_ok |=> o_rdata == WORD_ZERO;
	endproperty
	a_limit_absent: assert property (p_limit_absent) else $error("absent queue limit nonzero");
	property p_base_addr;
		##1 o_lookup_base_addr == (2*DATA_W)'($past(lookup_pfn)) * (2*DATA_W)'($past(page_size_r));
	endproperty
	a_base_addr: assert property (p_base_addr) else $error("queue base address wrong");
endmodule

// ### test/mqt_driver_model.sv
// Driver-side model that issues one register access at a time.
// Assumes the register bank registers read data on the same edge that takes the read.
`timescale 1ns/1ps
module mqt_driver_model import mqt_pkg::*; (
	input wire logic i_mclk,
	input wire logic [DATA_W-1:0] i_rdata,
	input wire logic i_rvalid,
	output mqt_req_type o_req
);
	initial o_req = '0;

	// One access, then a release that scrambles the idle address and data.
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q);
		@(posedge i_mclk);
		#1;
		o_req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
		@(posedge i_mclk);
		#1;
		q = i_rvalid ? i_rdata : 'x;
		o_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule

// ### test/mqt_regs_tb_top.sv
// Self-checking bench of the queue transport register bank.
// Assumes a 100 MHz clock and the driver model as the only bus master.
`timescale 1ns/1ps
module mqt_regs_tb_top import mqt_pkg::*;;
	// Identity values are arbitrary.
	localparam logic [31:0] SIG = 32'h1234_5678;
	localparam logic [31:0] DTYPE = 32'h0000_0003;
	localparam logic [31:0] VEND = 32'h0000_0042;
	localparam logic [63:0] OFF = 64'h8000_0001_0000_0005;
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	mqt_req_type req;
	logic i_used_ring_event = 1'b0;
	logic i_config_event = 1'b0;
	logic [QIDX_W-1:0] i_lookup_idx = '0;
	logic [DATA_W-1:0] o_rdata, o_device_status, o_page_size;
	logic o_rvalid, o_irq, o_doorbell_valid, o_device_reset;
	logic [QIDX_W-1:0] o_doorbell_index;
	logic [63:0] o_accepted_features, o_lookup_base_addr;
	mqt_qcfg_type o_lookup_cfg;
	logic [31:0] qs [5], qa [5], qp [5], psz, t, f0, f1, q;
	logic [ADDR_W-1:0] wo [10] = '{OFS_OFFERED_SEL, OFS_ACCEPTED, OFS_ACCEPTED_SEL, OFS_PAGE_SIZE,
		OFS_QUEUE_SEL, OFS_QUEUE_SIZE, OFS_ALIGN, OFS_DOORBELL, OFS_IRQ_ACK, 12'h0FC};
	int n_mismatch = 0;
	int check_count = 0;

	mqt_regs #(.SIGNATURE(SIG), .DEVICE_TYPE(DTYPE), .VENDOR(VEND), .OFFERED_FEATURES(OFF)) mqt_regs_inst (
		.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(req), .i_used_ring_event(i_used_ring_event),
		.i_config_event(i_config_event), .i_lookup_idx(i_lookup_idx), .o_rdata(o_rdata),
		.o_rvalid(o_rvalid), .o_irq(o_irq), .o_doorbell_valid(o_doorbell_valid),
		.o_doorbell_index(o_doorbell_index), .o_device_reset(o_device_reset),
		.o_device_status(o_device_status), .o_page_size(o_page_size),
		.o_accepted_features(o_accepted_features), .o_lookup_cfg(o_lookup_cfg),
		.o_lookup_base_addr(o_lookup_base_addr));
	mqt_driver_model mqt_driver_model_inst (.i_mclk(i_mclk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_req(req));

	initial forever #5 i_mclk = ~i_mclk;

	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		mqt_driver_model_inst.bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		mqt_driver_model_inst.bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic pulse(input logic cfg);
		@(posedge i_mclk);
		#1;
		i_config_event = cfg;
		i_used_ring_event = !cfg;
		@(posedge i_mclk);
		#1;
		i_config_event = 1'b0;
		i_used_ring_event = 1'b0;
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end

	initial begin
		void'($urandom(89));
		repeat (20) @(posedge i_mclk);
		#1;
		i_rst_b = 1'b1;
		rd(OFS_SIGNATURE, SIG);
		rd(OFS_DEVICE_TYPE, DTYPE);
		rd(OFS_VENDOR, VEND);
		wr(OFS_VERSION, $urandom);
		rd(OFS_VERSION, VERSION_LEGACY);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_OFFERED_SEL, i);
			rd(OFS_OFFERED, i < 2 ? OFF[i*32 +: 32] : 32'h0);
		end
		for (int i = 0; i < 10; i++) begin
			rd(wo[i], 32'h0);
		end
		psz = 32'h1 << ($urandom % 4 + 12);
		wr(OFS_PAGE_SIZE, psz);
		chk(o_page_size, psz);
		for (int i = 0; i < 5; i++) begin
			wr(OFS_QUEUE_SEL, i);
			rd(OFS_PAGE_NUMBER, 32'h0);
			rd(OFS_QUEUE_LIMIT, i < 4 ? QUEUE_SIZE_MAX : 32'h0);
			qs[i] = $urandom_range(256, 1);
			wr(OFS_QUEUE_SIZE, qs[i]);
			qa[i] = 32'h1 << (i + 2);
			wr(OFS_ALIGN, qa[i]);
			wr(OFS_ALIGN, qa[i] + 32'h3);
			qp[i] = $urandom_range(255, 1);
			wr(OFS_PAGE_NUMBER, qp[i]);
			rd(OFS_PAGE_NUMBER, i < 4 ? qp[i] : 32'h0);
		end
		for (int i = 3; i >= 0; i--) begin
			i_lookup_idx = QIDX_W'(i);
			@(posedge i_mclk);
			#1;
			chk(o_lookup_cfg, {qs[i], qa[i], 1'b1});
			chk(o_lookup_base_addr, 64'(qp[i]) * 64'(psz));
		end
		for (int i = 0; i < 5; i++) begin
			wr(OFS_DOORBELL, i);
			chk(o_doorbell_valid, i < 4);
			chk(o_doorbell_index, i < 4 ? i : 3);
			chk(o_irq, 1'b0);
		end
		pulse(1'b0);
		chk(o_irq, 1'b1);
		rd(OFS_IRQ_CAUSE, 32'h1);
		pulse(1'b1);
		rd(OFS_IRQ_CAUSE, 32'h3);
		wr(OFS_IRQ_ACK, 32'h1);
		rd(OFS_IRQ_CAUSE, 32'h2);
		chk(o_irq, 1'b1);
		wr(OFS_IRQ_ACK, 32'h2);
		rd(OFS_IRQ_CAUSE, 32'h0);
		chk(o_irq, 1'b0);
		fork
			wr(OFS_IRQ_ACK, 32'h1);
			pulse(1'b0);
		join
		rd(OFS_IRQ_CAUSE, 32'h1);
		wr(OFS_IRQ_ACK, 32'h1);
		rd(OFS_IRQ_CAUSE, 32'h0);
		f0 = $urandom;
		f1 = $urandom;
		wr(OFS_ACCEPTED_SEL, 32'h1);
		wr(OFS_ACCEPTED, f1);
		wr(OFS_ACCEPTED_SEL, 32'h0);
		wr(OFS_ACCEPTED, f0);
		wr(OFS_ACCEPTED_SEL, 32'h2);
		wr(OFS_ACCEPTED, ~f0);
		chk(o_accepted_features, {f1, f0});
		t = $urandom_range(255, 1);
		wr(OFS_STATUS, t);
		rd(OFS_STATUS, t);
		chk(o_device_status, t);
		pulse(1'b0);
		wr(OFS_STATUS, 32'h0);
		chk(o_device_reset, 1'b1);
		chk(o_device_status, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_QUEUE_SEL, i);
			rd(OFS_PAGE_NUMBER, 32'h0);
		end
		rd(OFS_IRQ_CAUSE, 32'h0);
		chk(o_page_size, psz);
		conclude();
	end
endmodule
